// ==== hw/sptm_pkg.sv ====
package sptm_pkg;

	// Host register offsets.
	localparam logic [7:0] REG_COMMAND = 8'h62;
	localparam logic [7:0] REG_WRITE_DATA = 8'h63;
	localparam logic [7:0] REG_MODE_CONTROL = 8'h6b;
	localparam logic [7:0] REG_READ_DATA = 8'h78;

	// Field positions in the pass-through command word.
	localparam int CMD_ADDR_LSB = 0;
	localparam int CMD_SLAVE_LSB = 8;
	localparam int CMD_READ_BIT = 10;
	localparam int CMD_NBYTES_LSB = 11;

	// Field positions in the modem mode and control word.
	localparam int MODE_MACRO_START_BIT = 0;
	localparam int MODE_MACRO_SEL_LSB = 1;
	localparam int MODE_CAL_BIT = 3;
	localparam int MODE_WAIT_BIT = 4;
	localparam int MODE_MODEM_LSB = 5;
	localparam int MODE_GAIN_MANUAL_BIT = 7;
	localparam int MODE_GAIN_STEP_LSB = 8;
	localparam int MODE_GAIN_WRITE_BIT = 11;

	// Modem mode codes.
	localparam logic [1:0] MODEM_IDLE = 2'h0;
	localparam logic [1:0] MODEM_RX = 2'h1;
	localparam logic [1:0] MODEM_TX = 2'h2;

	// Stored transaction entry layout and store regions.
	localparam int ENTRY_W = 29;
	localparam int ENT_DATA_LSB = 0;
	localparam int ENT_ADDR_LSB = 16;
	localparam int ENT_NBYTES_LSB = 24;
	localparam int ENT_LAST_BIT = 26;
	localparam int ENT_SLAVE_LSB = 27;
	localparam logic [4:0] AGC_BASE = 5'h10;
	localparam logic [4:0] CAL_BASE = 5'h18;
	localparam logic [1:0] CAL_SLAVE = 2'h1;

	// Values after reset.
	localparam logic [2:0] SELECT_IDLE = 3'h7;
	localparam logic [15:0] READ_DATA_RESET = 16'h0000;
	localparam logic [1:0] MODEM_RESET = MODEM_IDLE;

	typedef enum logic [1:0] {SYS_IDLE = 2'b01, SYS_WAIT = 2'b10} sptm_sys_state_e;
	typedef enum logic [3:0] {
		LNK_IDLE = 4'b0001, LNK_GUARD = 4'b0010, LNK_SHIFT = 4'b0100, LNK_HOLD = 4'b1000
	} sptm_link_state_e;

	// One transaction with the configuration of its slave attached.
	typedef struct packed {
		logic [1:0] slave;
		logic read;
		logic [1:0] nbytes;
		logic general;
		logic [3:0] bitsMinusOne;
		logic [7:0] addr;
		logic [15:0] data;
		logic [7:0] divider;
		logic [7:0] guard;
		logic cpol;
		logic cpha;
	} sptm_request_s;

endpackage

// ==== hw/sptm_master.sv ====
`timescale 1ns/1ps
// Behaviour
// - Master to three slaves, shared clock and data.
// - Three independent per-slave configuration sets.
// - Selected slave's configuration applied automatically.
// - Data write then command gives one transaction.
// - Host read data lands in read register.
// - Stored write macros paced without conflict.
// - Mode-control macro bits start a macro.
// - Transmit calibration on second chip select.
// - Gain control auto in receive, manual anywhere.
// - Calibration only transmit, gain auto only receive.
// - Macro-wait runs macro before calibration and gain.
// - Address byte plus zero to two data bytes.
// - General format allows non-byte field lengths.
module sptm_master
	import sptm_pkg::*;
(
	// Clocks and reset.
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic linkClk,
	// Host register port.
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regAddr,
	input wire logic [15:0] regWriteData,
	output logic [15:0] regReadData,
	// Transaction store loading.
	input wire logic progWrite,
	input wire logic [4:0] progIndex,
	input wire logic [ENTRY_W-1:0] progEntry,
	// Per-slave configuration sets.
	input wire logic [2:0][7:0] cfgClockDivider,
	input wire logic [2:0][7:0] cfgGuardCycles,
	input wire logic [2:0] cfgClockPolarity,
	input wire logic [2:0] cfgClockPhase,
	input wire logic [2:0] cfgGeneralFormat,
	input wire logic [2:0][3:0] cfgGeneralBitsMinusOne,
	// Receive gain control.
	input wire logic gainAutoStrobe,
	input wire logic [2:0] gainAutoStep,
	// Status.
	output logic sspBusy,
	// Serial link.
	output logic serialClock,
	output logic serialDataOut,
	input wire logic serialDataIn,
	output logic slaveSelectOutA_n,
	output logic slaveSelectOutB_n,
	output logic slaveSelectOutC_n
);

	typedef struct packed {
		sptm_sys_state_e state;
		logic [1:0] modemMode;
		logic gainManual;
		logic macroWait;
		logic hostPend;
		logic macroPend;
		logic [1:0] macroSel;
		logic calPend;
		logic gainPend;
		logic [2:0] gainStep;
		logic seqActive;
		logic seqForceCal;
		logic [4:0] seqIdx;
		logic hostRead;
		logic [15:0] command;
		logic [15:0] writeData;
		logic [15:0] readData;
		logic [15:0] regReadData;
		logic busy;
		sptm_request_s req;
		logic reqToggle;
		logic ackS1;
		logic ackS2;
		logic ackSeen;
		logic [31:0][ENTRY_W-1:0] store;
	} sptm_sys_s;

	typedef struct packed {
		logic rstS1;
		logic rstS2;
		sptm_link_state_e state;
		logic reqS1;
		logic reqS2;
		logic reqSeen;
		logic ackToggle;
		logic misoS1;
		logic misoS2;
		logic [7:0] divCnt;
		logic [7:0] guardCnt;
		logic [5:0] edgeCnt;
		logic [5:0] lastEdge;
		logic [31:0] tx;
		logic [31:0] rx;
		logic [15:0] rxResult;
		logic sclk;
		logic mosi;
		logic [2:0] selectN;
		sptm_request_s cur;
	} sptm_link_s;

	sptm_sys_s s;
	sptm_sys_s next_s;
	sptm_link_s lk;
	sptm_link_s next_lk;

	// Builds a transaction and attaches the target slave's own configuration set.
	function automatic sptm_request_s makeRequest(input logic [1:0] slave, input logic read,
			input logic [1:0] nbytes, input logic [7:0] addr, input logic [15:0] data);
		sptm_request_s r;
		logic [1:0] cfg;
		cfg = (slave == 2'h3) ? 2'h2 : slave;
		r.slave = slave;
		r.read = read;
		r.nbytes = (nbytes == 2'h3) ? 2'h2 : nbytes;
		r.general = cfgGeneralFormat[cfg];
		r.bitsMinusOne = cfgGeneralBitsMinusOne[cfg];
		r.addr = addr;
		r.data = data;
		r.divider = cfgClockDivider[cfg];
		r.guard = cfgGuardCycles[cfg];
		r.cpol = cfgClockPolarity[cfg];
		r.cpha = cfgClockPhase[cfg];
		return r;
	endfunction

	// System side: registers, source arbitration and the request handshake.
	always_comb begin
		logic launch;
		logic useStore;
		logic [4:0] idx;
		logic forceCal;
		logic [ENTRY_W-1:0] entry;
		logic [1:0] entrySlave;
		launch = 1'b0;
		useStore = 1'b0;
		idx = 5'h00;
		forceCal = 1'b0;
		entry = '0;
		entrySlave = 2'h0;
		next_s = s;
		next_s.ackS1 = lk.ackToggle;
		next_s.ackS2 = s.ackS1;
		next_s.regReadData = (regRead && regAddr == REG_READ_DATA) ? s.readData : 16'h0000;
		unique case (s.state)
			SYS_IDLE: begin
				if (s.hostPend) begin
					// One host command is exactly one transaction.
					next_s.req = makeRequest(s.command[CMD_SLAVE_LSB +: 2], s.command[CMD_READ_BIT],
						s.command[CMD_NBYTES_LSB +: 2], s.command[CMD_ADDR_LSB +: 8], s.writeData);
					next_s.hostRead = s.command[CMD_READ_BIT];
					next_s.hostPend = 1'b0;
					launch = 1'b1;
				end else if (s.seqActive) begin
					idx = s.seqIdx;
					forceCal = s.seqForceCal;
					useStore = 1'b1;
				end else if (s.macroPend && (s.macroWait || !(s.calPend || s.gainPend))) begin
					idx = {1'b0, s.macroSel, 2'b00};
					next_s.macroPend = 1'b0;
					useStore = 1'b1;
				end else if (s.calPend) begin
					idx = CAL_BASE;
					forceCal = 1'b1;
					next_s.calPend = 1'b0;
					useStore = 1'b1;
				end else if (s.gainPend) begin
					idx = AGC_BASE + {2'b00, s.gainStep};
					next_s.gainPend = 1'b0;
					useStore = 1'b1;
				end
				if (useStore) begin
					// Stored sequences are writes only and run one entry at a time.
					entry = s.store[idx];
					entrySlave = forceCal ? CAL_SLAVE : entry[ENT_SLAVE_LSB +: 2];
					next_s.req = makeRequest(entrySlave, 1'b0, entry[ENT_NBYTES_LSB +: 2],
						entry[ENT_ADDR_LSB +: 8], entry[ENT_DATA_LSB +: 16]);
					next_s.hostRead = 1'b0;
					next_s.seqActive = !entry[ENT_LAST_BIT] && (idx < AGC_BASE || forceCal);
					next_s.seqForceCal = forceCal;
					next_s.seqIdx = idx + 5'h01;
					launch = 1'b1;
				end
				if (launch) begin
					// The request word stays frozen until the link acknowledges it.
					next_s.reqToggle = !s.reqToggle;
					next_s.state = SYS_WAIT;
				end
			end
			SYS_WAIT: begin
				if (s.ackS2 != s.ackSeen) begin
					next_s.ackSeen = s.ackS2;
					if (s.hostRead) begin
						next_s.readData = lk.rxResult;
					end
					next_s.state = SYS_IDLE;
				end
			end
		endcase
		// Register writes come after dispatch so a new request is never lost.
		if (regWrite) begin
			if (regAddr == REG_WRITE_DATA) begin
				next_s.writeData = regWriteData;
			end
			if (regAddr == REG_COMMAND) begin
				next_s.command = regWriteData;
				next_s.hostPend = 1'b1;
			end
			if (regAddr == REG_MODE_CONTROL) begin
				next_s.modemMode = regWriteData[MODE_MODEM_LSB +: 2];
				next_s.gainManual = regWriteData[MODE_GAIN_MANUAL_BIT];
				next_s.macroWait = regWriteData[MODE_WAIT_BIT];
				if (regWriteData[MODE_MACRO_START_BIT]) begin
					next_s.macroPend = 1'b1;
					next_s.macroSel = regWriteData[MODE_MACRO_SEL_LSB +: 2];
				end
				if (regWriteData[MODE_CAL_BIT]) begin
					next_s.calPend = 1'b1;
				end
				if (regWriteData[MODE_GAIN_WRITE_BIT] && regWriteData[MODE_GAIN_MANUAL_BIT]) begin
					next_s.gainPend = 1'b1;
					next_s.gainStep = regWriteData[MODE_GAIN_STEP_LSB +: 3];
				end
			end
		end
		// Automatic gain steps are honoured only in receive mode.
		if (gainAutoStrobe && s.modemMode == MODEM_RX && !s.gainManual) begin
			next_s.gainPend = 1'b1;
			next_s.gainStep = gainAutoStep;
		end
		// Calibration is dropped once the modem is no longer transmitting.
		if (next_s.modemMode != MODEM_TX) begin
			next_s.calPend = 1'b0;
		end
		if (progWrite) begin
			next_s.store[progIndex] = progEntry;
		end
		next_s.busy = (next_s.state == SYS_WAIT) || next_s.hostPend || next_s.macroPend
			|| next_s.calPend || next_s.gainPend || next_s.seqActive;
		if (reset) begin
			next_s = '0;
			next_s.state = SYS_IDLE;
			next_s.modemMode = MODEM_RESET;
			next_s.readData = READ_DATA_RESET;
		end
	end

	// System side register stage.
	always_ff @(posedge sys_clk) begin
		s <= next_s;
	end

	// Link side: guard, select, clock generation and shifting on the link clock.
	always_comb begin
		logic [4:0] bits;
		logic leading;
		bits = 5'h00;
		leading = 1'b0;
		next_lk = lk;
		next_lk.rstS1 = reset;
		next_lk.rstS2 = lk.rstS1;
		next_lk.reqS1 = s.reqToggle;
		next_lk.reqS2 = lk.reqS1;
		next_lk.misoS1 = serialDataIn;
		next_lk.misoS2 = lk.misoS1;
		unique case (lk.state)
			LNK_IDLE: begin
				next_lk.selectN = SELECT_IDLE;
				if (lk.reqS2 != lk.reqSeen) begin
					// The request word is stable here; the toggle crossed two flops first.
					next_lk.reqSeen = lk.reqS2;
					next_lk.cur = s.req;
					if (s.req.general) begin
						bits = {1'b0, s.req.bitsMinusOne} + 5'h01;
						next_lk.tx = {16'(s.req.data << (4'hf - s.req.bitsMinusOne)), 16'h0000};
					end else begin
						bits = 5'h08 + {s.req.nbytes, 3'b000};
						next_lk.tx = {s.req.addr, s.req.read ? 16'h0000 : s.req.data, 8'h00};
					end
					next_lk.lastEdge = {bits, 1'b0} - 6'h01;
					next_lk.rx = 32'h00000000;
					next_lk.guardCnt = 8'h00;
					next_lk.sclk = s.req.cpol; // Settle polarity before the select falls.
					next_lk.state = LNK_GUARD;
				end
			end
			LNK_GUARD: begin
				if (lk.guardCnt >= lk.cur.guard) begin
					// Slave code three clocks the bus with no select.
					for (int i = 0; i < 3; i++) begin
						next_lk.selectN[i] = !(lk.cur.slave == 2'(i));
					end
					if (!lk.cur.cpha) begin
						next_lk.mosi = lk.tx[31];
						next_lk.tx = {lk.tx[30:0], 1'b0};
					end
					next_lk.divCnt = 8'h00;
					next_lk.edgeCnt = 6'h00;
					next_lk.state = LNK_SHIFT;
				end else begin
					next_lk.guardCnt = lk.guardCnt + 8'h01;
				end
			end
			LNK_SHIFT: begin
				if (lk.divCnt == lk.cur.divider) begin
					// Half period elapsed: make one clock edge.
					next_lk.divCnt = 8'h00;
					next_lk.sclk = !lk.sclk;
					next_lk.edgeCnt = lk.edgeCnt + 6'h01;
					leading = !lk.edgeCnt[0];
					if (leading == lk.cur.cpha) begin
						if (lk.edgeCnt != lk.lastEdge) begin
							next_lk.mosi = lk.tx[31];
							next_lk.tx = {lk.tx[30:0], 1'b0};
						end
					end else begin
						next_lk.rx = {lk.rx[30:0], lk.misoS2};
					end
					if (lk.edgeCnt == lk.lastEdge) begin
						next_lk.state = LNK_HOLD;
					end
				end else begin
					next_lk.divCnt = lk.divCnt + 8'h01;
				end
			end
			LNK_HOLD: begin
				if (lk.divCnt == lk.cur.divider) begin
					next_lk.selectN = SELECT_IDLE;
					next_lk.mosi = 1'b0;
					next_lk.ackToggle = !lk.ackToggle;
					// Only the requested read bytes are returned.
					if (!lk.cur.read) begin
						next_lk.rxResult = 16'h0000;
					end else if (lk.cur.general || lk.cur.nbytes == 2'h2) begin
						next_lk.rxResult = lk.rx[15:0];
					end else if (lk.cur.nbytes == 2'h1) begin
						next_lk.rxResult = {8'h00, lk.rx[7:0]};
					end else begin
						next_lk.rxResult = 16'h0000;
					end
					next_lk.state = LNK_IDLE;
				end else begin
					next_lk.divCnt = lk.divCnt + 8'h01;
				end
			end
			default: begin
				next_lk.state = LNK_IDLE;
			end
		endcase
		// Reset reaches this domain through its own two-flop chain.
		// The chain keeps sampling while held, otherwise the link would drop out of reset while reset is still held.
		if (lk.rstS2) begin
			next_lk = '0;
			next_lk.rstS1 = reset;
			next_lk.rstS2 = lk.rstS1;
			next_lk.state = LNK_IDLE;
			next_lk.selectN = SELECT_IDLE;
		end
	end

	// Link side register stage.
	always_ff @(posedge linkClk) begin
		lk <= next_lk;
	end

	// Outputs straight from flops in their own domains.
	assign regReadData = s.regReadData;
	assign sspBusy = s.busy;
	assign serialClock = lk.sclk;
	assign serialDataOut = lk.mosi;
	assign slaveSelectOutA_n = lk.selectN[0];
	assign slaveSelectOutB_n = lk.selectN[1];
	assign slaveSelectOutC_n = lk.selectN[2];

endmodule

// ==== test/sptm_master_properties.sv ====
`timescale 1ns/1ps
module sptm_chk
	import sptm_pkg::*;
(
	// Clocks and reset.
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic linkClk,
	// Host side.
	input wire logic regRead,
	input wire logic regWrite,
	input wire logic [7:0] regAddr,
	input wire logic [15:0] regReadData,
	input wire logic sspBusy,
	// Link side.
	input wire logic [2:0][7:0] cfgClockDivider,
	input wire logic [2:0] cfgClockPolarity,
	input wire logic serialClock,
	input wire logic slaveSelectOutA_n,
	input wire logic slaveSelectOutB_n,
	input wire logic slaveSelectOutC_n
);
	// Selects gathered active high so one count covers all three.
	wire logic [2:0] selOn = ~{slaveSelectOutC_n, slaveSelectOutB_n, slaveSelectOutA_n};

	// A select only moves while the port admits to being busy.
	AST_ONE_SELECT: assert property (@(posedge linkClk) disable iff (reset) $countones(selOn) <= 1)
		else $error("More than one slave selected.");
	AST_SEL_BUSY: assert property (@(posedge sys_clk) disable iff (reset) (|selOn) |-> sspBusy)
		else $error("Slave selected while port idle.");
	AST_CMD_BUSY: assert property (@(posedge sys_clk) disable iff (reset)
		regWrite && regAddr == REG_COMMAND |=> ##[0:1] sspBusy) else $error("Command did not start.");
	AST_READ_OTHER: assert property (@(posedge sys_clk) disable iff (reset)
		regRead && regAddr != REG_READ_DATA |=> regReadData == 16'h0000) else $error("Odd read not zero.");
	AST_READ_ONE_CYCLE: assert property (@(posedge sys_clk) disable iff (reset)
		!regRead |=> regReadData == 16'h0000) else $error("Read data held too long.");
	AST_RESET_QUIET: assert property (@(posedge sys_clk) reset |=> !sspBusy && regReadData == 16'h0000)
		else $error("Outputs active after reset.");
	// The clock must sit at the slave's own idle level when its select opens.
	AST_POL_A: assert property (@(posedge linkClk) disable iff (reset)
		$fell(slaveSelectOutA_n) |-> serialClock == cfgClockPolarity[0]) else $error("Bad idle clock A.");
	AST_POL_B: assert property (@(posedge linkClk) disable iff (reset)
		$fell(slaveSelectOutB_n) |-> serialClock == cfgClockPolarity[1]) else $error("Bad idle clock B.");
	AST_SEL_HOLD: assert property (@(posedge linkClk) disable iff (reset)
		$fell(slaveSelectOutC_n) |-> !slaveSelectOutC_n [*2]) else $error("Select C dropped early.");
	AST_HALF_PERIOD: assert property (@(posedge linkClk) disable iff (reset)
		!slaveSelectOutA_n && $changed(serialClock) && cfgClockDivider[0] != 8'h00
		|-> $past(serialClock, 2) == $past(serialClock)) else $error("Clock A too fast.");
endmodule
bind sptm_master sptm_chk u_chk (.sys_clk(sys_clk), .reset(reset), .linkClk(linkClk), .regRead(regRead),
	.regWrite(regWrite), .regAddr(regAddr), .regReadData(regReadData), .sspBusy(sspBusy),
	.cfgClockDivider(cfgClockDivider), .cfgClockPolarity(cfgClockPolarity), .serialClock(serialClock),
	.slaveSelectOutA_n(slaveSelectOutA_n), .slaveSelectOutB_n(slaveSelectOutB_n),
	.slaveSelectOutC_n(slaveSelectOutC_n));

// ==== test/sptm_slave_model.sv ====
`timescale 1ns/1ps
module sptm_slave_model #(
	parameter logic [31:0] PATTERN = 32'hc3a5_96e1
) (
	// Link pins.
	input wire logic linkClk,
	input wire logic serialClock,
	input wire logic serialDataOut,
	input wire logic [2:0] selN,
	input wire logic [2:0] cphaCfg,
	output logic serialDataIn,
	// What the slaves saw.
	output logic [31:0] rxBits,
	output logic [5:0] rxCount,
	output logic [7:0] frames,
	output logic [5:0] history
);
	bit tog;
	logic [2:0] selQ = 3'h7;
	logic clkQ, idleLvl, cph;
	logic [1:0] who;
	int idx;
	wire logic [1:0] pick = !selN[0] ? 2'h0 : (!selN[1] ? 2'h1 : 2'h2);
	initial frames = 8'h00;
	// Reacts a link cycle after the clock moves; a released line toggles so no stale bit survives.
	always @(posedge linkClk) begin
		tog <= ~tog;
		selQ <= selN;
		clkQ <= serialClock;
		if (selN == 3'h7) begin
			serialDataIn <= tog;
			if (selQ != 3'h7) begin
				frames <= frames + 8'h01;
				history <= {history[3:0], who};
			end
		end else if (selQ == 3'h7) begin
			who <= pick;
			cph <= cphaCfg[pick];
			idleLvl <= serialClock;
			idx <= cphaCfg[pick] ? -1 : 0;
			rxBits <= 32'h0;
			rxCount <= 6'h00;
			serialDataIn <= cphaCfg[pick] ? tog : PATTERN[31];
		end else if (serialClock != clkQ) begin
			if ((serialClock != idleLvl) != cph) begin
				rxBits <= {rxBits[30:0], serialDataOut};
				rxCount <= rxCount + 6'h01;
			end else begin
				idx <= idx + 1;
				serialDataIn <= PATTERN[30 - idx];
			end
		end
	end
endmodule

// ==== test/testbench.sv ====
`timescale 1ns/1ps
module testbench
	import sptm_pkg::*;
;
	localparam logic [31:0] PAT = 32'hc3a5_96e1;
	logic sys_clk = 1'b0;
	logic linkClk = 1'b0;
	logic reset = 1'b1;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic progWrite = 1'b0;
	logic gainAutoStrobe = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [15:0] regWriteData = 16'h0000;
	logic [4:0] progIndex = 5'h00;
	logic [ENTRY_W-1:0] progEntry = '0;
	logic [2:0] gainAutoStep = 3'h0;
	logic [2:0][7:0] cfgDiv = {8'h03, 8'h04, 8'h03};
	logic [2:0][7:0] cfgGuard = {8'h02, 8'h05, 8'h03};
	logic [2:0] cfgPol = 3'h2;
	logic [2:0] cfgPha = 3'h4;
	logic [2:0] cfgGen = 3'h4;
	logic [2:0][3:0] cfgBits = {4'hb, 4'h0, 4'h0};
	logic [15:0] regReadData;
	logic sspBusy, serialClock, serialDataOut, serialDataIn, selA_n, selB_n, selC_n;
	logic [31:0] rxBits;
	logic [5:0] rxCount, history;
	logic [7:0] frames;
	int mismatches = 0;
	int num_checks = 0;

	// Link clock is offset so its edges never meet the system clock's; its period is three system periods.
	always #2.5 sys_clk = ~sys_clk;
	initial begin
		#1.7;
		forever #7.5 linkClk = ~linkClk;
	end

	sptm_master u_dut (.sys_clk(sys_clk), .reset(reset), .linkClk(linkClk), .regWrite(regWrite),
		.regRead(regRead), .regAddr(regAddr), .regWriteData(regWriteData), .regReadData(regReadData),
		.progWrite(progWrite), .progIndex(progIndex), .progEntry(progEntry), .cfgClockDivider(cfgDiv),
		.cfgGuardCycles(cfgGuard), .cfgClockPolarity(cfgPol), .cfgClockPhase(cfgPha),
		.cfgGeneralFormat(cfgGen), .cfgGeneralBitsMinusOne(cfgBits), .gainAutoStrobe(gainAutoStrobe),
		.gainAutoStep(gainAutoStep), .sspBusy(sspBusy), .serialClock(serialClock),
		.serialDataOut(serialDataOut), .serialDataIn(serialDataIn), .slaveSelectOutA_n(selA_n),
		.slaveSelectOutB_n(selB_n), .slaveSelectOutC_n(selC_n));
	sptm_slave_model #(.PATTERN(PAT)) u_slave (.linkClk(linkClk), .serialClock(serialClock),
		.serialDataOut(serialDataOut), .selN({selC_n, selB_n, selA_n}), .cphaCfg(cfgPha),
		.serialDataIn(serialDataIn), .rxBits(rxBits), .rxCount(rxCount), .frames(frames), .history(history));

	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		num_checks++;
		if (seen !== want) begin
			mismatches++;
			$display("FAIL at %0t: saw %h expected %h", $time, seen, want);
		end
	endtask

	task automatic give_verdict();
		$display("Checks %0d, mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Read data stands only in the cycle after the strobe, so it is taken at that falling edge.
	task automatic reg_op(input logic wr, input logic [7:0] a, input logic [15:0] d, output logic [15:0] q);
		@(negedge sys_clk);
		regWrite = wr;
		regRead = !wr;
		regAddr = a;
		regWriteData = d;
		@(negedge sys_clk);
		regWrite = 1'b0;
		regRead = 1'b0;
		q = regReadData;
	endtask

	task automatic wait_idle();
		int n;
		n = 0;
		repeat (3) @(negedge sys_clk);
		while (sspBusy !== 1'b0) begin
			@(negedge sys_clk);
			n++;
			if (n > 20000) begin
				mismatches++;
				$display("FAIL at %0t: port stuck busy", $time);
				give_verdict();
			end
		end
		// The slave model counts the closing select a link cycle late, so let it catch up.
		repeat (2) @(negedge linkClk);
	endtask

	task automatic prog(input logic [4:0] ix, input logic [1:0] s, input logic last, input logic [7:0] a);
		@(negedge sys_clk);
		progWrite = 1'b1;
		progIndex = ix;
		progEntry = {s, last, 2'h1, a, ~a, 8'h00};
		@(negedge sys_clk);
		progWrite = 1'b0;
	endtask

	// One mode write and an optional gain strobe, then frame count, slave order and last frame are compared.
	task automatic seq(input logic [15:0] mw, input logic stb, input logic [7:0] n, input logic [5:0] hist,
		input logic [15:0] last);
		logic [7:0] f0;
		logic [15:0] q;
		f0 = frames;
		reg_op(1'b1, REG_MODE_CONTROL, mw, q);
		@(negedge sys_clk);
		gainAutoStrobe = stb;
		@(negedge sys_clk);
		gainAutoStrobe = 1'b0;
		wait_idle();
		check(frames - f0, n);
		check(history & ~(6'h3f << (2 * n)), hist);
		if (n != 0) check(rxBits[15:0], last);
	endtask

	function automatic logic [31:0] mosi_exp(logic [1:0] s, logic rd, logic [1:0] nb, logic [7:0] a,
		logic [15:0] d);
		if (s == 2'h2) return {20'h0, d[11:0]};
		if (rd) d = 16'h0000;
		return nb == 2'h0 ? {24'h0, a} : (nb == 2'h1 ? {16'h0, a, d[15:8]} : {8'h0, a, d});
	endfunction

	// The read answer is the tail of the slave's bit stream.
	function automatic logic [15:0] miso_tail(int n, int k);
		logic [31:0] s;
		s = PAT >> (32 - n);
		return s[15:0] & ((16'h1 << k) - 16'h1);
	endfunction

	initial begin
		logic [15:0] rv, d;
		logic [1:0] s, nb, ne;
		logic rd;
		logic [7:0] a, f0;
		logic [7:0] bad [4] = '{8'h00, REG_COMMAND, REG_WRITE_DATA, REG_MODE_CONTROL};
		rv = 16'($urandom(38823));
		repeat (6) @(negedge sys_clk);
		reset = 1'b0;
		repeat (4) @(negedge linkClk);
		foreach (bad[i]) begin
			reg_op(1'b0, bad[i], 16'h0000, rv);
			check(rv, 0);
		end
		for (int i = 0; i < 15; i++) begin
			s = i < 3 ? 2'(i) : 2'($urandom_range(2, 0));
			nb = i == 3 ? 2'h3 : 2'($urandom_range(2, 0));
			ne = nb == 2'h3 ? 2'h2 : nb;
			rd = 1'($urandom);
			a = 8'($urandom);
			d = 16'($urandom);
			cfgDiv[0] = 8'($urandom_range(6, 3));
			f0 = frames;
			reg_op(1'b1, REG_WRITE_DATA, d, rv);
			reg_op(1'b1, REG_COMMAND, {3'h0, nb, rd, s, a}, rv);
			wait_idle();
			check(frames - f0, 1);
			check(history[1:0], s);
			check(rxCount, s == 2'h2 ? 12 : 8 + 8 * ne);
			check(rxBits, mosi_exp(s, rd, ne, a, d));
			if (rd && (ne != 2'h0 || s == 2'h2)) begin
				reg_op(1'b0, REG_READ_DATA, 16'h0000, rv);
				check(rv, s == 2'h2 ? miso_tail(12, 12) : miso_tail(8 + 8 * ne, 8 * ne));
			end
		end
		prog(5'h04, 2'h0, 1'b0, 8'h11);
		prog(5'h05, 2'h1, 1'b1, 8'h22);
		prog(5'h18, 2'h0, 1'b1, 8'h33);
		for (int g = 0; g < 8; g++) prog(5'h10 + 5'(g), 2'h0, 1'b1, 8'h40 + 8'(g));
		// Gain steps are only asked for while the port is idle, so they never clash.
		gainAutoStep = 3'($urandom_range(7, 0));
		seq(16'h0028, 1'b0, 0, 6'h00, 16'h0);
		seq(16'h0048, 1'b0, 1, 6'h01, 16'h33cc);
		seq(16'h0040, 1'b1, 0, 6'h00, 16'h0);
		seq(16'h0020, 1'b1, 1, 6'h00, {8'h40 + gainAutoStep, ~(8'h40 + gainAutoStep)});
		seq(16'h0d80, 1'b0, 1, 6'h00, 16'h45ba);
		seq(16'h0003, 1'b0, 2, 6'h01, 16'h22dd);
		seq(16'h005b, 1'b0, 3, 6'h05, 16'h33cc);
		seq(16'h004b, 1'b0, 3, 6'h11, 16'h22dd);
		give_verdict();
	end
endmodule
